// ### servo_sequence_stop_config_test.sv
`timescale 1ns/1ps
module servo_sequence_stop_config_test;
	import ssc_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic small_motor = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	ssc_seq_in_t want_seq = '0;
	ssc_meas_t want_meas = '0;
	ssc_seq_in_t seq_in;
	ssc_meas_t meas;
	ssc_seq_out_t seq_out;
	logic [31:0] rd;
	logic [63:0] mv = 64'h0;
	logic [15:0] prev;
	logic [15:0] cfg;
	int n_fail = 0;
	int n_tests = 0;
	int cycles = 0;

	ssc_host_model host_u (.mclk(mclk), .want_seq(want_seq), .want_meas(want_meas),
		.seq_in(seq_in), .meas(meas));
	ssc_top dut_u (.mclk(mclk), .srst(srst), .small_motor(small_motor), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.seq_in(seq_in), .meas(meas), .seq_out(seq_out));

	initial begin
		forever #25 mclk = ~mclk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			end_of_test();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
		int n;
		@(posedge mclk);
		haddr <= {24'h0, a};
		htrans <= SSC_HTRANS_NONSEQ;
		hwrite <= w;
		hsel <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hwdata <= wd;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		rd = hrdata;
	endtask

	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		chk(name, rd, exp);
	endtask

	// The bus reset stands in for the power cycle that loads the shadow word.
	task automatic rst();
		@(posedge mclk);
		srst <= 1'b1;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	// Allows for the model's edge, the two-flop pin synchroniser and the output flop.
	task automatic drive(input logic [6:0] v, input logic [31:0] mask, input logic [31:0] exp);
		@(posedge mclk);
		want_seq <= v;
		want_meas <= mv;
		repeat (8) @(posedge mclk);
		chk("seq_out", {23'h0, seq_out} & mask, exp);
	endtask

	initial begin
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		repeat (3) @(posedge mclk);
		rdchk("stored", SSC_CFG_OFS, 32'h08cc);
		rdchk("shadow", SSC_SHADOW_OFS, 32'h08cc);
		rdchk("threshold", SSC_THR_OFS, 32'h0);
		bus(8'h20, 1'b1, 32'hffff);
		rdchk("unmapped", 8'h20, 32'h0);
		chk("hresp", {31'h0, hresp}, 32'h0);
		$display("test reset_values done");
		mv = {16'h0200, 48'h0};
		drive(7'b1111000, 32'h1e1, 32'h1e0);
		drive(7'b0000100, 32'h182, 32'h002);
		$display("test default_decode done");
		prev = 16'h08cc;
		for (int c = 0; c < 4; c++) begin
			cfg = 16'h0003 | 16'(c << 12);
			bus(SSC_CFG_OFS, 1'b1, {16'h0, cfg});
			rdchk("stored", SSC_CFG_OFS, {16'h0, cfg});
			rdchk("shadow", SSC_SHADOW_OFS, {16'h0, prev});
			drive(7'b0000000, 32'h100, {23'h0, prev[0], 8'h0});
			rst();
			rdchk("shadow", SSC_SHADOW_OFS, {16'h0, cfg});
			bus(SSC_THR_OFS, 1'b1, 32'h0100);
			mv = {4{16'h0050}};
			mv[(3 - c) * 16 +: 16] = 16'h0200;
			drive(7'b0000000, 32'h1e1, 32'h1e1);
			prev = cfg;
		end
		drive(7'b0010000, 32'h040, 32'h0);
		drive(7'b0001000, 32'h020, 32'h0);
		drive(7'b0000001, 32'h001, 32'h0);
		$display("test shadow_and_switch done");
		bus(SSC_CFG_OFS, 1'b1, 32'h0500);
		rst();
		drive(7'b0000100, 32'h002, 32'h0);
		drive(7'b1110000, 32'h008, 32'h008);
		drive(7'b1110001, 32'h008, 32'h0);
		drive(7'b0000100, 32'h010, 32'h010);
		drive(7'b0000110, 32'h010, 32'h0);
		drive(7'b1110010, 32'h104, 32'h0);
		bus(SSC_CFG_OFS, 1'b1, 32'h0280);
		rst();
		drive(7'b1110010, 32'h114, 32'h114);
		bus(SSC_CFG_OFS, 1'b1, 32'h02c0);
		rst();
		drive(7'b1110010, 32'h114, 32'h104);
		$display("test over_travel done");
		end_of_test();
	end
endmodule

// ### ssc_host_model.sv
`timescale 1ns/1ps
// Host controller stand-in: it changes its levels only just after a rising edge.
module ssc_host_model (
	input wire logic mclk,
	input wire ssc_pkg::ssc_seq_in_t want_seq,
	input wire ssc_pkg::ssc_meas_t want_meas,
	output ssc_pkg::ssc_seq_in_t seq_in,
	output ssc_pkg::ssc_meas_t meas
);
	import ssc_pkg::*;
	initial begin
		seq_in = '0;
		meas = '0;
	end
	always @(posedge mclk) begin
		seq_in <= want_seq;
		meas <= want_meas;
	end
endmodule

// ### ssc_pkg.sv
package ssc_pkg;
	localparam logic [7:0] SSC_CFG_OFS = 8'h00;
	localparam logic [7:0] SSC_SHADOW_OFS = 8'h04;
	localparam logic [7:0] SSC_STATUS_OFS = 8'h08;
	localparam logic [7:0] SSC_THR_OFS = 8'h0c;
	localparam int SSC_B_SERVO_ALWAYS = 0;
	localparam int SSC_B_SENSOR_FORCE = 1;
	localparam int SSC_B_FWD_PERMIT = 2;
	localparam int SSC_B_REV_PERMIT = 3;
	localparam int SSC_B_FREE_RUN = 6;
	localparam int SSC_B_DB_HOLD = 7;
	localparam int SSC_B_OT_ESTOP = 8;
	localparam int SSC_B_OT_LOCK = 9;
	localparam int SSC_B_DEV_KEEP = 10;
	localparam int SSC_B_PSW_OFF = 11;
	localparam int SSC_B_COND_LO = 12;
	localparam int SSC_B_COND_HI = 13;
	// Factory value with bit 7 cleared; bit 7 is added for small motors.
	localparam logic [15:0] SSC_CFG_RESET = 16'h084c;
	localparam logic [15:0] SSC_DB_BIT = 16'h0080;
	localparam logic [1:0] SSC_HTRANS_NONSEQ = 2'h2;
	typedef enum logic [1:0] {SSC_COND_TORQUE, SSC_COND_SPEED, SSC_COND_ACCEL,
		SSC_COND_DEV} ssc_cond_t;
	typedef enum logic [1:0] {SSC_STOP_DB, SSC_STOP_FREE, SSC_STOP_ESTOP} ssc_stop_t;
	typedef struct packed {
		logic run_cmd;
		logic sensor_on_in;
		logic forward_prohibit_in;
		logic reverse_prohibit_in;
		logic alarm;
		logic motor_stopped;
		logic torque_mode;
	} ssc_seq_in_t;
	typedef struct packed {
		logic servo_on;
		logic sensor_on;
		logic fwd_permit;
		logic rev_permit;
		logic dyn_brake;
		logic estop_torque_sel;
		logic pos_lock;
		logic dev_clear;
		logic p_only;
	} ssc_seq_out_t;
	typedef struct packed {
		logic [15:0] torque;
		logic [15:0] speed;
		logic [15:0] accel;
		logic [15:0] deviation;
	} ssc_meas_t;
endpackage

// ### ssc_pswitch.sv
`timescale 1ns/1ps
module ssc_pswitch (
	input wire logic mclk,
	input wire logic srst,
	input wire logic enable,
	input wire ssc_pkg::ssc_cond_t cond,
	input wire ssc_pkg::ssc_meas_t meas,
	input wire logic [15:0] threshold,
	output logic p_only
);
	import ssc_pkg::*;
	logic [15:0] level;
	always_comb begin
		case (cond)
			SSC_COND_TORQUE: level = meas.torque;
			SSC_COND_SPEED: level = meas.speed;
			SSC_COND_ACCEL: level = meas.accel;
			default: level = meas.deviation;
		endcase
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			p_only <= 1'b0;
		end else begin
			p_only <= enable && (level > threshold);
		end
	end
	a_pswitch_off: assert property (@(posedge mclk) disable iff (srst)
		!$past(enable) |-> !p_only) else $error("P switch active while disabled");
endmodule

// ### ssc_sync.sv
`timescale 1ns/1ps
module ssc_sync (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [4:0] din,
	output logic [4:0] dout
);
	logic [4:0] stage1;
	always_ff @(posedge mclk) begin
		if (srst) begin
			stage1 <= 5'h00;
			dout <= 5'h00;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule

// ### ssc_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Bit 0 clear: servo follows run command; set: servo on without run command, still off on alarm.
// - Bit 1 set forces sensor-on high internally, pin ignored.
// - Bit 2 set always permits forward drive, ignoring the prohibit input.
// - Bit 3 set always permits reverse drive, ignoring the prohibit input.
// - Abnormal stop uses dynamic brake if bit 6 clear, coasts if set.
// - After stop, bit 7 set keeps dynamic brake on, clear releases it.
// - Bit 6 set with bit 8 clear releases the brake after stop.
// - Bit 7 only acts on small motors; its default follows motor size.
// - Over-travel with bit 8 set stops at emergency-stop torque, else per bit 6.
// - After over-travel stop, bit 9 clear turns servo off, set locks position.
// - In torque mode the stop method follows bit 6 only.
// - Servo off with alarm clears deviation counter unless bit A set.
// - Bit b clear enables P switching, set disables it.
// - Bits d,C pick torque, speed, acceleration or deviation condition.
// - Condition met changes PI to P control, never in torque mode.
// - Written config values take effect only after the next power-up; threshold writes act at once.
module ssc_top (
	input wire logic mclk,
	input wire logic srst,
	input wire logic small_motor,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire ssc_pkg::ssc_seq_in_t seq_in,
	input wire ssc_pkg::ssc_meas_t meas,
	output ssc_pkg::ssc_seq_out_t seq_out
);
	import ssc_pkg::*;
	logic [15:0] stored_cfg;
	logic [15:0] shadow;
	logic [15:0] threshold;
	logic loaded;
	logic strap_small;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [4:0] pins_sync;
	logic run_s, sensor_s, fwd_pro_s, rev_pro_s, alarm_s;
	logic p_only;
	logic addr_ok;
	logic [15:0] next_stored;

	// Pins from the motion controller are asynchronous to mclk.
	ssc_sync u_sync (
		.mclk(mclk),
		.srst(srst),
		.din({seq_in.run_cmd, seq_in.sensor_on_in, seq_in.forward_prohibit_in,
			seq_in.reverse_prohibit_in, seq_in.alarm}),
		.dout(pins_sync)
	);
	assign {run_s, sensor_s, fwd_pro_s, rev_pro_s, alarm_s} = pins_sync;

	function automatic logic ofs_valid(input logic [7:0] a);
		ofs_valid = (a == SSC_CFG_OFS) || (a == SSC_SHADOW_OFS) ||
			(a == SSC_STATUS_OFS) || (a == SSC_THR_OFS);
	endfunction

	// Bus slave: zero wait states, always OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_ok = ofs_valid(haddr[7:0]);

	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (hready) begin
			wr_pend <= hsel && htrans == SSC_HTRANS_NONSEQ && hwrite && addr_ok;
			wr_addr <= haddr[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans == SSC_HTRANS_NONSEQ && !hwrite) begin
			case (haddr[7:0])
				SSC_CFG_OFS: hrdata <= {16'h0000, stored_cfg};
				SSC_SHADOW_OFS: hrdata <= {16'h0000, shadow};
				SSC_STATUS_OFS: hrdata <= {23'h000000, seq_out};
				SSC_THR_OFS: hrdata <= {16'h0000, threshold};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// The stored word survives a reset: only writes change it, so a later
	// reset release (the power-up) is what brings it into effect.
	always_comb begin
		next_stored = stored_cfg;
		if (wr_pend && wr_addr == SSC_CFG_OFS) begin
			next_stored = hwdata[15:0];
		end
	end

	// Strap is caught at the release, never under reset.
	always_ff @(posedge mclk) begin
		if (srst) begin
			loaded <= 1'b0;
		end else begin
			loaded <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			strap_small <= 1'b0;
		end else if (!loaded) begin
			strap_small <= small_motor;
		end
	end

	// Marks that the default has been loaded once. Reset must not clear it,
	// or every later reset would wipe the written word before the copy.
	logic cfg_init = 1'b0;
	always_ff @(posedge mclk) begin
		if (!srst) begin
			cfg_init <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!cfg_init) begin
			stored_cfg <= SSC_CFG_RESET | (small_motor ? SSC_DB_BIT : 16'h0000);
		end else begin
			stored_cfg <= next_stored;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			threshold <= 16'h0000;
		end else if (wr_pend && wr_addr == SSC_THR_OFS) begin
			threshold <= hwdata[15:0];
		end
	end

	// Shadow is taken once, one cycle after release, when the word is settled.
	always_ff @(posedge mclk) begin
		if (srst) begin
			shadow <= SSC_CFG_RESET;
		end else if (loaded && !took) begin
			shadow <= stored_cfg;
		end
	end
	logic took;
	always_ff @(posedge mclk) begin
		if (srst) begin
			took <= 1'b0;
		end else begin
			took <= loaded;
		end
	end
	logic [15:0] act;
	assign act = took ? shadow : stored_cfg;

	// Decoding from the active copy.
	logic overtravel, stopping, ot_stop, db_hold;
	ssc_stop_t method;
	assign overtravel = (!act[SSC_B_FWD_PERMIT] && fwd_pro_s) ||
		(!act[SSC_B_REV_PERMIT] && rev_pro_s);
	assign stopping = alarm_s || overtravel;
	assign ot_stop = overtravel && !alarm_s && !seq_in.torque_mode;
	assign db_hold = act[SSC_B_DB_HOLD] && strap_small;

	always_comb begin
		if (ot_stop && act[SSC_B_OT_ESTOP]) begin
			method = SSC_STOP_ESTOP;
		end else if (act[SSC_B_FREE_RUN]) begin
			method = SSC_STOP_FREE;
		end else begin
			method = SSC_STOP_DB;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			seq_out.servo_on <= 1'b0;
			seq_out.sensor_on <= 1'b0;
			seq_out.fwd_permit <= 1'b0;
			seq_out.rev_permit <= 1'b0;
		end else begin
			seq_out.servo_on <= (act[SSC_B_SERVO_ALWAYS] || run_s) && !alarm_s &&
				!(ot_stop && seq_in.motor_stopped && !act[SSC_B_OT_LOCK]);
			seq_out.sensor_on <= act[SSC_B_SENSOR_FORCE] || sensor_s;
			seq_out.fwd_permit <= act[SSC_B_FWD_PERMIT] || !fwd_pro_s;
			seq_out.rev_permit <= act[SSC_B_REV_PERMIT] || !rev_pro_s;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			seq_out.dyn_brake <= 1'b0;
			seq_out.estop_torque_sel <= 1'b0;
			seq_out.pos_lock <= 1'b0;
		end else begin
			if (!stopping) begin
				seq_out.dyn_brake <= 1'b0;
			end else if (!seq_in.motor_stopped) begin
				seq_out.dyn_brake <= (method == SSC_STOP_DB);
			end else if (act[SSC_B_FREE_RUN] && !act[SSC_B_OT_ESTOP]) begin
				seq_out.dyn_brake <= 1'b0;
			end else begin
				seq_out.dyn_brake <= db_hold;
			end
			seq_out.estop_torque_sel <= stopping && method == SSC_STOP_ESTOP;
			seq_out.pos_lock <= ot_stop && seq_in.motor_stopped && act[SSC_B_OT_LOCK];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			seq_out.dev_clear <= 1'b0;
		end else begin
			seq_out.dev_clear <= !seq_out.servo_on && alarm_s && !act[SSC_B_DEV_KEEP];
		end
	end

	ssc_pswitch u_psw (
		.mclk(mclk),
		.srst(srst),
		.enable(!act[SSC_B_PSW_OFF] && !seq_in.torque_mode),
		.cond(ssc_cond_t'(act[SSC_B_COND_HI:SSC_B_COND_LO])),
		.meas(meas),
		.threshold(threshold),
		.p_only(p_only)
	);
	assign seq_out.p_only = p_only;

	a_shadow_hold: assert property (@(posedge mclk) disable iff (srst)
		took && $past(took) |-> $stable(shadow)) else $error("shadow changed");
	a_fwd_permit: assert property (@(posedge mclk) disable iff (srst)
		!$past(srst) && $past(act[SSC_B_FWD_PERMIT]) |-> seq_out.fwd_permit)
		else $error("fwd blocked");
	a_rev_permit: assert property (@(posedge mclk) disable iff (srst)
		!$past(srst) && $past(act[SSC_B_REV_PERMIT]) |-> seq_out.rev_permit)
		else $error("rev blocked");
	a_sensor_force: assert property (@(posedge mclk) disable iff (srst)
		!$past(srst) && $past(act[SSC_B_SENSOR_FORCE]) |-> seq_out.sensor_on)
		else $error("sensor low");
	a_free_run: assert property (@(posedge mclk) disable iff (srst)
		!$past(srst) && $past(act[SSC_B_FREE_RUN] && !act[SSC_B_OT_ESTOP]) |->
		!seq_out.dyn_brake)
		else $error("brake in free run");
	a_estop_sel: assert property (@(posedge mclk) disable iff (srst)
		seq_out.estop_torque_sel |-> $past(act[SSC_B_OT_ESTOP] && !seq_in.torque_mode))
		else $error("estop without bit 8");
	a_dev_keep: assert property (@(posedge mclk) disable iff (srst)
		!$past(srst) && $past(act[SSC_B_DEV_KEEP]) |-> !seq_out.dev_clear)
		else $error("dev cleared");
	a_servo_always: assert property (@(posedge mclk) disable iff (srst)
		!$past(srst) && $past(act[SSC_B_SERVO_ALWAYS] && !alarm_s && !overtravel) |->
		seq_out.servo_on)
		else $error("servo off");
	c_pswitch: cover property (@(posedge mclk) seq_out.p_only);
	c_estop: cover property (@(posedge mclk) seq_out.estop_torque_sel);
	c_lock: cover property (@(posedge mclk) seq_out.pos_lock);
endmodule
